// ---- verilog/serial_rx_core.sv ----
// Functional notes
// - async mode oversamples the line 8 or 16 times per bit, by select bit.
// - start bit after half a bit low; then every 8th/16th sample is a bit.
// - receiver uses transmitter length, nine-bit, order, parity settings.
// - only one stop bit checked; hunting restarts right after it.
// - biphase mode matches chosen preamble pattern; length zero skips it.
// - receive polarity bit selects the biphase input stream polarity.
// - one-bit delimiter means encoded zero; otherwise three-period sync pattern.
// - holding register sync bit: 0 data sync, 1 command sync.
// - biphase hunting samples quarters; any low quarter starts a frame.
// - valid start keeps timing; a mismatch keeps hunting until hcnt reaches tlen+2, then idles.
// - missing mid-bit transition sets biphase error; clear-status clears it.
// - clocked mode samples every baud tick; a low sample is a start.
// - finished character loads holding register, sets ready; overrun if set.
// - reading holding register clears ready; clear-status clears overrun.
// - parity even, odd, space, mark or none.
// - parity mismatch sets parity error unless none; clear-status clears it.
// - parity codes 6 and 7 select multidrop; parity bit marks address.
// - send-address command marks next written character as an address.
// - multidrop character with parity bit one sets parity error.
// - transmitter holds line high for guard bits after stop bits.
// - with guard, ready waits for start bit; empty waits for guard end.
// - nine-bit select forces nine data bits over the length field.
module serial_rx_core
    import rx_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV = BAUD_DIV_RST
) (
    input  wire logic        pclk,    // system clock, 50 MHz
    input  wire logic        presetn, // async reset, active low
    input  wire logic        psel,    // apb select
    input  wire logic        penable, // apb enable
    input  wire logic        pwrite,  // apb direction
    input  wire logic [7:0]  paddr,   // apb byte address
    input  wire logic [31:0] pwdata,  // apb write data
    output logic      [31:0] prdata,  // apb read data
    output logic             pready,  // apb ready
    output logic             pslverr, // apb error
    input  wire logic        rxd,     // serial in
    output logic             txd      // serial out
);

    typedef struct packed {
        rx_state_type st;
        logic [15:0]  div;
        logic [4:0]   smp;
        logic [4:0]   txs;
        logic [3:0]   bcnt;
        logic         ph;
        logic         h0;
        logic [8:0]   sr;
        logic         par;
        logic [35:0]  win;
        logic [6:0]   hcnt;
        logic         styp;
        logic [12:0]  mode;
        logic [6:0]   biph;
        logic [7:0]   guard;
        logic [15:0]  cd;
        logic [8:0]   rx_holding_reg;
        logic         rsync;
        logic         rdy;
        logic         ovr;
        logic         pe;
        logic         me;
        logic [31:0]  rdata;
    } core_type;

    core_type s, n;

    logic        line;
    logic        tick;
    logic [4:0]  osr;
    logic [4:0]  hlf;
    logic [4:0]  per;
    logic [3:0]  nb;
    logic [2:0]  pmode;
    logic        pen;
    logic        bip;
    logic        pol;
    logic        bitv;
    logic        wr;
    logic        rd_rhr;
    logic        clr;
    logic        senda;
    logic        thr_wr;
    logic        tx_ready;
    logic        tx_empty;
    logic        tx_bit;
    logic [5:0]  tlen;
    logic [35:0] w;
    logic [35:0] mask;
    logic        mt_d;
    logic        mt_c;
    logic        fin;
    logic        me_hit;
    logic        par_now;
    logic [8:0]  ch;
    logic        pe_hit;

    line_sync3 u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (rxd),
        .dout    (line)
    );

    // start template, oldest half-bit in the upper end
    function automatic logic [35:0] tmpl(input logic cmd);
        logic [35:0] t;
        logic        b;
        logic [1:0]  pp;
        t = '1;
        pp = s.biph[B_PP+:2];
        for (int i = 0; i < 15; i++) begin
            b = (pp == PP_ONES) || (pp == PP_ZO && i[0])
                || (pp == PP_OZ && !i[0]);
            if (i < int'(s.biph[B_PL+:4]))
                t = {t[33:0], b ^ pol, !(b ^ pol)};
        end
        if (s.mode[M_ONEBIT]) t = {t[33:0], pol, !pol};
        else t = {t[29:0], cmd ? SYNC_CMD : SYNC_DATA};
        return t;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a inside {CTRL_OFS, MODE_OFS, STAT_OFS, RHR_OFS,
                         THR_OFS, GUARD_OFS, BAUD_OFS, BIPH_OFS};
    endfunction

    // clocked mode uses one sample per bit
    assign osr = s.mode[M_SYNC] ? OSR_CLK
               : (s.mode[M_OVER] ? OSR8 : OSR16);
    assign hlf = osr >> 1;
    assign tick = s.div == s.cd;
    assign bip = s.mode[M_MAN];
    assign per = bip ? hlf : osr;
    assign pol = s.biph[B_POL];
    assign nb = char_bits(s.mode[M_NINE], s.mode[M_LEN+:2]);
    assign pmode = s.mode[M_PAR+:3];
    assign pen = par_on(pmode);
    assign bitv = bip ? s.h0 ^ pol : line;
    assign tx_bit = tick && s.txs == osr - 5'h01;

    assign tlen = {1'h0, s.biph[B_PL+:4], 1'h0}
                + (s.mode[M_ONEBIT] ? 6'h02 : 6'h06);
    assign mask = ~(36'hF_FFFF_FFFF << tlen);
    assign w = {s.win[34:0], line};
    assign mt_d = ((w ^ tmpl(1'h0)) & mask) == '0;
    assign mt_c = !s.mode[M_ONEBIT] && ((w ^ tmpl(1'h1)) & mask) == '0;

    assign wr = psel && penable && pwrite;
    assign rd_rhr = psel && penable && !pwrite && paddr == RHR_OFS;
    assign clr = wr && paddr == CTRL_OFS && pwdata[C_CLR];
    assign senda = wr && paddr == CTRL_OFS && pwdata[C_SENDA];
    assign thr_wr = wr && paddr == THR_OFS;

    always_comb begin
        n = s;
        fin = 1'h0;
        me_hit = 1'h0;
        par_now = s.par;
        n.div = tick ? 16'h0000 : s.div + 16'h0001;
        if (tick) n.txs = (s.txs == osr - 5'h01) ? 5'h00 : s.txs + 5'h01;

        unique case (s.st)
            R_IDLE: if (tick) begin
                if (bip) begin
                    // quarter boundary; biphase needs oversampling
                    if (s.smp == (osr >> 2) - 5'h01) begin
                        n.smp = 5'h00;
                        if (!line) begin
                            n.st = R_HUNT;
                            n.win = {35'h7_FFFF_FFFF, 1'h0};
                            n.hcnt = 7'h01;
                        end
                    end else begin
                        n.smp = s.smp + 5'h01;
                    end
                end else if (line) begin
                    n.smp = 5'h00;
                end else if (s.mode[M_SYNC]
                             || s.smp == hlf - 5'h01) begin
                    n.st = R_DATA;
                    n.smp = 5'h00;
                    n.bcnt = 4'h0;
                end else begin
                    n.smp = s.smp + 5'h01;
                end
            end
            R_HUNT: if (tick) begin
                if (s.smp == hlf - 5'h01) begin
                    n.smp = 5'h00;
                    n.win = w;
                    n.hcnt = s.hcnt + 7'h01;
                    if (mt_d || mt_c) begin
                        n.st = R_DATA;
                        n.styp = mt_c;
                        n.bcnt = 4'h0;
                        n.ph = 1'h0;
                    end else if (s.hcnt >= {1'h0, tlen} + 7'h02) begin
                        n.st = R_IDLE;
                    end
                end else begin
                    n.smp = s.smp + 5'h01;
                end
            end
            R_DATA, R_PAR, R_STOP: if (tick) begin
                if (s.smp == per - 5'h01) begin
                    n.smp = 5'h00;
                    n.ph = !s.ph;
                    if (bip && !s.ph) begin
                        n.h0 = line;
                    end else begin
                        if (bip && s.h0 == line) me_hit = 1'h1;
                        unique case (s.st)
                            R_DATA: begin
                                n.sr = s.mode[M_MSB] ? {s.sr[7:0], bitv}
                                                     : {bitv, s.sr[8:1]};
                                n.bcnt = s.bcnt + 4'h1;
                                if (s.bcnt == nb - 4'h1) begin
                                    if (pen) n.st = R_PAR;
                                    else if (bip) fin = 1'h1;
                                    else n.st = R_STOP;
                                end
                            end
                            R_PAR: begin
                                par_now = bitv;
                                n.par = bitv;
                                if (bip) fin = 1'h1;
                                else n.st = R_STOP;
                            end
                            default: fin = 1'h1;
                        endcase
                    end
                end else begin
                    n.smp = s.smp + 5'h01;
                end
            end
            default: n.st = R_IDLE;
        endcase

        // one stop bit only; hunting resumes at once
        if (fin) begin
            n.st = R_IDLE;
            n.smp = 5'h00;
        end

        ch = s.mode[M_MSB] ? n.sr & nmask(nb) : n.sr >> (4'h9 - nb);
        pe_hit = mdrop(pmode) ? par_now
               : pen && par_now != par_bit(ch, nb, pmode, 1'h0);

        // clears first so a same-cycle event wins
        if (rd_rhr) n.rdy = 1'h0;
        if (clr) begin
            n.ovr = 1'h0;
            n.pe = 1'h0;
            n.me = 1'h0;
        end
        if (me_hit) n.me = 1'h1;
        if (fin) begin
            n.rx_holding_reg = ch;
            n.rsync = s.styp;
            n.rdy = 1'h1;
            if (s.rdy && !rd_rhr) n.ovr = 1'h1;
            if (pe_hit) n.pe = 1'h1;
        end

        if (wr) begin
            unique case (paddr)
                MODE_OFS:  n.mode = pwdata[12:0];
                GUARD_OFS: n.guard = pwdata[7:0];
                BAUD_OFS:  n.cd = pwdata[15:0];
                BIPH_OFS:  n.biph = pwdata[6:0];
                default:   n.mode = s.mode;
            endcase
        end

        // read data fixed in setup phase, held through access
        if (psel && !penable) begin
            n.rdata = '0;
            unique case (paddr)
                MODE_OFS:  n.rdata[12:0] = s.mode;
                GUARD_OFS: n.rdata[7:0] = s.guard;
                BAUD_OFS:  n.rdata[15:0] = s.cd;
                BIPH_OFS:  n.rdata[6:0] = s.biph;
                RHR_OFS: begin
                    n.rdata[8:0] = s.rx_holding_reg;
                    n.rdata[RHR_SYNC] = s.rsync;
                end
                STAT_OFS: begin
                    n.rdata[S_RDY] = s.rdy;
                    n.rdata[S_TX_READY_FLAG] = tx_ready;
                    n.rdata[S_OVR] = s.ovr;
                    n.rdata[S_PE] = s.pe;
                    n.rdata[S_TXE] = tx_empty;
                    n.rdata[S_ME] = s.me;
                end
                default:   n.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= R_IDLE;
            s.mode <= MODE_RST;
            s.biph <= BIPH_RST;
            s.guard <= GUARD_RST;
            s.cd <= BAUD_DIV;
            s.win <= '1;
        end else begin
            s <= n;
        end
    end

    tx_guard_shifter u_tx (
        .pclk      (pclk),
        .presetn   (presetn),
        .bit_tick  (tx_bit),
        .wr_en     (thr_wr),
        .wr_data   (pwdata[8:0]),
        .addr_cmd  (senda),
        .nbits     (nb),
        .pmode     (pmode),
        .msb_first (s.mode[M_MSB]),
        .stops     (s.mode[M_STOP+:2]),
        .guard     (s.guard),
        .txd       (txd),
        .tx_ready  (tx_ready),
        .tx_empty  (tx_empty)
    );

    assign prdata = s.rdata;
    assign pready = 1'h1;
    assign pslverr = psel && penable && !mapped(paddr);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_char_in;
        fin && !rd_rhr;
    endsequence

    sequence s_loaded;
        s.rdy && s.rx_holding_reg == $past(ch);
    endsequence

    a_load_ready:
        assert property (s_char_in |=> s_loaded)
        else $error("character not loaded with ready");
    a_overrun_set:
        assert property (fin && !rd_rhr && s.rdy |=> s.ovr)
        else $error("overrun missed");
    a_read_clear:
        assert property (rd_rhr && !fin |=> !s.rdy)
        else $error("ready not cleared by read");
    a_status_clear:
        assert property (clr && !fin && !me_hit |=> !s.ovr && !s.pe && !s.me)
        else $error("clear-status left a flag");
    a_stop_hunt:
        assert property (s.st == R_STOP && fin |=> s.st == R_IDLE)
        else $error("no hunt after first stop");
    a_clocked_start:
        assert property (s.mode[M_SYNC] && !bip && s.st == R_IDLE && tick
                         && !line |=> s.st == R_DATA)
        else $error("low sample not taken as start");
    a_multidrop_addr:
        assert property (fin && mdrop(pmode) && par_now |=> s.pe)
        else $error("address character not flagged");
    a_biphase_err:
        assert property (me_hit |=> s.me)
        else $error("biphase violation not flagged");
endmodule // serial_rx_core

// ---- verilog/rx_pkg.sv ----
package rx_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] MODE_OFS  = 8'h04;
    localparam logic [7:0] STAT_OFS  = 8'h08;
    localparam logic [7:0] RHR_OFS   = 8'h0C;
    localparam logic [7:0] THR_OFS   = 8'h10;
    localparam logic [7:0] GUARD_OFS = 8'h14;
    localparam logic [7:0] BAUD_OFS  = 8'h18;
    localparam logic [7:0] BIPH_OFS  = 8'h1C;

    // field positions
    localparam int C_CLR = 8, C_SENDA = 19;
    localparam int M_SYNC = 0, M_OVER = 1, M_LEN = 2, M_NINE = 4;
    localparam int M_MSB = 5, M_PAR = 6, M_STOP = 9, M_MAN = 11;
    localparam int M_ONEBIT = 12;
    localparam int B_PL = 0, B_PP = 4, B_POL = 6;
    localparam int S_RDY = 0, S_TX_READY_FLAG = 1, S_OVR = 5, S_PE = 7;
    localparam int S_TXE = 9, S_ME = 20, RHR_SYNC = 15;

    // reset values
    localparam logic [12:0] MODE_RST     = 13'h010C;
    localparam logic [6:0]  BIPH_RST     = 7'h00;
    localparam logic [7:0]  GUARD_RST    = 8'h00;
    localparam logic [15:0] BAUD_DIV_RST = 16'h001A;

    // samples per bit
    localparam logic [4:0] OSR16 = 5'h10, OSR8 = 5'h08, OSR_CLK = 5'h01;

    localparam logic [2:0] PAR_EVEN = 3'h0, PAR_ODD = 3'h1;
    localparam logic [2:0] PAR_SPACE = 3'h2, PAR_MARK = 3'h3;
    localparam logic [1:0] PP_ONES = 2'h0, PP_ZO = 2'h2, PP_OZ = 2'h3;
    localparam logic [5:0] SYNC_DATA = 6'h07, SYNC_CMD = 6'h38;

    typedef enum logic [2:0] {
        R_IDLE, R_HUNT, R_DATA, R_PAR, R_STOP
    } rx_state_type;

    function automatic logic [3:0] char_bits(input logic nine,
                                             input logic [1:0] len);
        return nine ? 4'h9 : 4'h5 + {2'h0, len};
    endfunction

    function automatic logic par_on(input logic [2:0] m);
        return !(m[2] && !m[1]);
    endfunction

    function automatic logic mdrop(input logic [2:0] m);
        return m[2] && m[1];
    endfunction

    function automatic logic [8:0] nmask(input logic [3:0] nb);
        return ~(9'h1FF << nb);
    endfunction

    function automatic logic par_bit(input logic [8:0] d,
                                     input logic [3:0] nb,
                                     input logic [2:0] m,
                                     input logic addr);
        logic x;
        x = ^(d & nmask(nb));
        if (mdrop(m)) return addr;
        case (m)
            PAR_EVEN:  return x;
            PAR_ODD:   return ~x;
            PAR_SPACE: return 1'h0;
            PAR_MARK:  return 1'h1;
            default:   return 1'h0;
        endcase
    endfunction

endpackage

// ---- verilog/line_sync3.sv ----
module line_sync3 (
    input  wire logic pclk,     // system clock
    input  wire logic presetn,  // async reset, active low
    input  wire logic din,      // raw pin level
    output logic      dout      // filtered level
);
    typedef struct packed {
        logic [2:0] sh;
        logic       lvl;
    } sync_type;

    sync_type s, n;

    always_comb begin
        n = s;
        n.sh = {s.sh[1:0], din};
        // change accepted only once stages two and three agree
        if (s.sh[1] == s.sh[2]) n.lvl = s.sh[2];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s <= '1;
        else s <= n;
    end

    assign dout = s.lvl;
endmodule // line_sync3

// ---- verilog/tx_guard_shifter.sv ----
module tx_guard_shifter
    import rx_pkg::*;
(
    input  wire logic       pclk,      // system clock
    input  wire logic       presetn,   // async reset, active low
    input  wire logic       bit_tick,  // one pulse per bit period
    input  wire logic       wr_en,     // holding register write
    input  wire logic [8:0] wr_data,   // character to send
    input  wire logic       addr_cmd,  // send-address command
    input  wire logic [3:0] nbits,     // data bits per character
    input  wire logic [2:0] pmode,     // parity mode
    input  wire logic       msb_first, // bit order
    input  wire logic [1:0] stops,     // stop count field
    input  wire logic [7:0] guard,     // idle bits after stops
    output logic            txd,       // serial out
    output logic            tx_ready,  // holding register free
    output logic            tx_empty   // nothing left to send
);
    typedef struct packed {
        logic [8:0]  hold;
        logic        full;
        logic        haddr;
        logic        apend;
        logic        busy;
        logic [10:0] sr;
        logic [9:0]  rem;
        logic        txd;
    } tx_type;

    tx_type s, n;

    function automatic logic [10:0] frame(input logic [8:0] d,
                                          input logic a);
        logic [10:0] f;
        f = '1;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(nbits))
                f[i] = msb_first ? d[int'(nbits) - 1 - i] : d[i];
        end
        if (par_on(pmode)) f[nbits] = par_bit(d, nbits, pmode, a);
        return f;
    endfunction

    always_comb begin
        n = s;
        if (addr_cmd) n.apend = 1'h1;
        // writes while the holding register is full are dropped
        if (wr_en && !s.full) begin
            n.hold = wr_data;
            n.full = 1'h1;
            n.haddr = s.apend;
            n.apend = 1'h0;
        end
        if (bit_tick) begin
            if (s.busy && s.rem != 10'h000) begin
                n.txd = s.sr[0];
                n.sr = {1'h1, s.sr[10:1]};
                n.rem = s.rem - 10'h001;
            end else begin
                n.busy = 1'h0;
                n.txd = 1'h1;
                // reload only after stops and guard: ready tracks start
                if (s.full) begin
                    n.busy = 1'h1;
                    n.txd = 1'h0;
                    n.full = 1'h0;
                    n.sr = frame(s.hold, s.haddr);
                    n.rem = {6'h00, nbits} + {9'h000, par_on(pmode)}
                          + ((stops == 2'h0) ? 10'h001 : 10'h002)
                          + {2'h0, guard};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.txd <= 1'h1;
        end else begin
            s <= n;
        end
    end

    assign txd = s.txd;
    assign tx_ready = !s.full;
    assign tx_empty = !s.full && !s.busy;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_empty_guard:
        assert property ($rose(tx_empty) |-> $past(bit_tick)
                         && $past(s.rem) == 10'h000)
        else $error("empty before guard ended");
    a_ready_start:
        assert property ($rose(tx_ready) |-> !txd && s.busy)
        else $error("ready rose without start bit");
    a_guard_high:
        assert property (s.busy && s.rem < {2'h0, guard} |-> txd)
        else $error("line low during guard");
endmodule // tx_guard_shifter

// ---- dv/remote_dev.sv ----
module remote_dev (
    input  wire logic        pclk, // system clock
    input  wire logic        go,   // start one frame
    input  wire logic [11:0] bits, // frame, first bit in bit 0
    input  wire logic [3:0]  len,  // bits in the frame
    input  wire logic [4:0]  per,  // clocks per bit
    output logic             rxd   // line into the receiver
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rxd = 1'b1;
    always @(posedge pclk) begin
        if (go) begin
            for (int i = 0; i < len; i++) begin
                rxd <= bits[i];
                repeat (per) @(posedge pclk);
            end
            rxd <= 1'b1; // idle line is pulled high
        end
    end
endmodule // remote_dev

// ---- dv/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rx_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        rxd, txd, go, perr, over, a, p, pe;
    logic [7:0]  paddr, d;
    logic [31:0] pwdata, prdata, r;
    logic [11:0] bits, tx_exp;
    logic [3:0]  len;
    logic [4:0]  per;
    logic [2:0]  pm;
    int          fails, check_count, i;

    serial_rx_core #(.BAUD_DIV(16'h0000)) serial_rx_core_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
    remote_dev remote_dev_i (.pclk(pclk), .go(go), .bits(bits),
        .len(len), .per(per), .rxd(rxd));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 8) begin
            fails++;
            final_report();
        end
    endtask

    task raw(input logic [11:0] fb, input logic [3:0] n,
             input logic [4:0] pp);
        bits <= fb;
        len <= n;
        per <= pp;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (12 * pp) @(posedge pclk);
    endtask

    // frame goes out lsb first; waits out the whole frame
    task send(input logic [7:0] dd, input logic pb, input logic hp,
              input logic [4:0] pp);
        raw(hp ? {2'b11, pb, dd, 1'b0} : {3'b111, dd, 1'b0},
            hp ? 4'hB : 4'hA, pp);
    endtask

    task wait_ready;
        int i;
        for (i = 0; i < 10; i++) begin
            apb(1'b0, STAT_OFS, 32'h0);
            if (r[S_RDY] === 1'b1) break;
        end
        if (i == 10) begin
            fails++;
            final_report();
        end
    endtask

    function automatic logic exp_par(logic [7:0] dd, logic [2:0] m,
                                     logic adr);
        case (m)
            3'h0: return ^dd;
            3'h1: return ~^dd;
            3'h2: return 1'b0;
            3'h3: return 1'b1;
            default: return adr;
        endcase
    endfunction

    // encoded-zero delimiter, then lsb first; one is high half first
    function automatic logic [11:0] biph_frame(logic [4:0] dd);
        logic [11:0] f;
        f = 12'h002;
        for (int j = 0; j < 5; j++) f[2 * j + 2 +: 2] = {~dd[j], dd[j]};
        return f;
    endfunction

    initial begin
        {psel, penable, pwrite, go, presetn} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        bits = 12'hFFF;
        len = 4'h0;
        per = 5'h10;
        fails = 0;
        check_count = 0;
        void'($urandom(88));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, MODE_OFS, 32'h0);
        chk(r, {19'h0, MODE_RST});
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, perr}, 32'h1);
        $display("test reset_values done");
        for (int m = 0; m < 16; m++) begin
            over = m[3];
            pm = m[2:0];
            apb(1'b1, MODE_OFS, 32'h0C | pm << M_PAR | over << M_OVER);
            d = $urandom;
            a = $urandom;
            // wrong parity only where a parity is checked
            p = exp_par(d, pm, a) ^ (a & ~pm[2]);
            pe = pm[2] ? (pm[1] & a) : a;
            send(d, p, pm != 3'h4 && pm != 3'h5, over ? 5'h08 : 5'h10);
            wait_ready();
            apb(1'b0, RHR_OFS, 32'h0);
            chk(r & 32'h1FF, {24'h0, d});
            apb(1'b0, STAT_OFS, 32'h0);
            chk({31'h0, r[S_RDY]}, 32'h0);
            chk({31'h0, r[S_PE]}, {31'h0, pe});
            apb(1'b1, CTRL_OFS, 32'h1 << C_CLR);
            apb(1'b0, STAT_OFS, 32'h0);
            chk({31'h0, r[S_PE]}, 32'h0);
        end
        $display("test parity_modes done");
        apb(1'b1, MODE_OFS, 32'h10C);
        send(8'hA5, 1'b0, 1'b0, 5'h10);
        send(8'h3C, 1'b0, 1'b0, 5'h10);
        wait_ready();
        chk({31'h0, r[S_OVR]}, 32'h1);
        apb(1'b0, RHR_OFS, 32'h0);
        chk(r & 32'h1FF, 32'h3C);
        apb(1'b1, CTRL_OFS, 32'h1 << C_CLR);
        apb(1'b0, STAT_OFS, 32'h0);
        chk({31'h0, r[S_OVR]}, 32'h0);
        $display("test overrun done");
        apb(1'b1, GUARD_OFS, 32'h2);
        apb(1'b1, THR_OFS, 32'h55);
        apb(1'b0, STAT_OFS, 32'h0);
        chk({31'h0, r[S_TXE]}, 32'h0);
        tx_exp = {3'b111, 8'h55, 1'b0};
        for (i = 0; i < 40 && txd !== 1'b0; i++) @(posedge pclk);
        if (i == 40) begin
            fails++;
            final_report();
        end
        repeat (7) @(posedge pclk);
        // mid-bit: start, data, stop, two guard bits
        for (int k = 0; k < 12; k++) begin
            chk({31'h0, txd}, {31'h0, tx_exp[k]});
            apb(1'b0, STAT_OFS, 32'h0);
            chk({30'h0, r[S_TXE], r[S_TX_READY_FLAG]}, 32'h1);
            repeat (13) @(posedge pclk);
        end
        apb(1'b0, STAT_OFS, 32'h0);
        chk({30'h0, r[S_TXE], r[S_TX_READY_FLAG]}, 32'h3);
        $display("test guard done");
        // last half kept high so no false start follows the frame
        apb(1'b1, MODE_OFS, 32'h1900);
        d = {4'h0, 4'($urandom)};
        raw(biph_frame(d[4:0]), 4'hC, 5'h08);
        wait_ready();
        chk({31'h0, r[S_ME]}, 32'h0);
        apb(1'b0, RHR_OFS, 32'h0);
        chk(r & 32'h81FF, {24'h0, d});
        raw(12'hFFE, 4'hC, 5'h08);
        wait_ready();
        chk({31'h0, r[S_ME]}, 32'h1);
        apb(1'b0, RHR_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h1 << C_CLR);
        apb(1'b0, STAT_OFS, 32'h0);
        chk({31'h0, r[S_ME]}, 32'h0);
        $display("test biphase done");
        apb(1'b1, BAUD_OFS, 32'h3);
        apb(1'b1, MODE_OFS, 32'h10D);
        d = $urandom;
        send(d, 1'b0, 1'b0, 5'h04);
        wait_ready();
        apb(1'b0, RHR_OFS, 32'h0);
        chk(r & 32'h1FF, {24'h0, d});
        $display("test clocked done");
        final_report();
    end
endmodule // tb
